/* src/tac_coord.sv */
/*
  Two-axis coordinated motion: picks the primary axis, computes the
  proportion factor and the limited primary velocity, scales the
  follower velocity and gates on-the-fly target updates. Registers sit
  behind an Avalon-MM slave with waitrequest.
  Assumes two ramp generators on the same clock that follow the
  command structs and report position, speed magnitude and stop.
*/
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
// Behaviour
// - Limited primary velocity is follower limit divided by proportion.
// - Effective primary limit is max of limited and own limit.
// - Primary axis runs its own acceleration, deceleration, with the effective limit as velocity.
// - Follower velocity is primary actual velocity times proportion.
// - Coordination ends when primary reaches target; follower finishes.
// - Follower final stop uses its own ramp settings.
// - Stop on either axis aborts; other axis finishes on own ramp.
// - On-the-fly targets accepted only on trajectory within 3 steps.
// - Primary is larger displacement; tie goes to higher limit.
// - Proportion is abs ratio follower/primary, rounded to 1/4096.
// - Mode bit 9 enables coordinated motion.
// - Paired latch bit 8 holds axis-0 target until axis-1 write.
`timescale 1ns/1ps
`include "tac_defines.svh"

module tac_coord
  import tac_pkg::*;
#(
  parameter int unsigned TOLERANCE = `TAC_TOL
) (
  input wire logic clock, // 125 MHz system clock
  input wire logic reset, // Asynchronous, active high
  input wire logic [8:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Slave not ready
  input wire tac_axis_in_t axis0_in, // Axis 0 ramp state
  input wire tac_axis_in_t axis1_in, // Axis 1 ramp state
  output tac_axis_cmd_t axis0_cmd, // Axis 0 ramp command
  output tac_axis_cmd_t axis1_cmd, // Axis 1 ramp command
  output logic coordinated_active // Coordinated move running
);

  localparam int PW = `TAC_POS_W;
  localparam int VW = `TAC_VEL_W;
  localparam int FW = `TAC_PF_W;
  localparam int DW = `TAC_DIV_W;

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Magnitude of a position difference, one bit wider than positions
  function automatic logic [PW:0] abs_diff(input logic signed [PW-1:0] a,
                                           input logic signed [PW-1:0] b);
    logic signed [PW:0] d;
    d = {a[PW-1], a} - {b[PW-1], b};
    abs_diff = d[PW] ? (PW+1)'(-d) : d;
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    be_merge = r;
  endfunction

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic ack;
  logic [31:0] mode_reg;
  logic [VW-1:0] vlim [2];
  logic signed [PW-1:0] tgt_reg [2], act_tgt [2], cand_tgt [2];
  logic rejected;
  logic prim;
  logic [FW-1:0] pf;
  logic [VW-1:0] velocity_limit_eff;
  tac_state_t state;

  tac_axis_in_t ax_in [2];
  assign ax_in[0] = axis0_in;
  assign ax_in[1] = axis1_in;

  // One wait cycle on every access keeps the read mux off the bus path
  wire acc = avs_read | avs_write;
  wire wr = avs_write & ack;
  wire [6:0] widx = avs_address[8:2];
  assign avs_waitrequest = acc & ~ack;

  // Address decode
  wire hit_mode = widx == `TAC_IDX_MODE;
  wire hit_v0 = widx == `TAC_IDX_VLIM0;
  wire hit_v1 = widx == `TAC_IDX_VLIM1;
  wire hit_t0 = widx == `TAC_IDX_TGT0;
  wire hit_t1 = widx == `TAC_IDX_TGT1;
  wire hit_st = widx == `TAC_IDX_STAT;
  wire sync_en = mode_reg[`TAC_BIT_SYNC];
  wire coord_en = mode_reg[`TAC_BIT_COORD];
  wire wr_t0 = wr & hit_t0;
  wire wr_t1 = wr & hit_t1;
  wire [31:0] wd_mode = be_merge(mode_reg, avs_writedata, avs_byteenable);
  wire [31:0] wd_v0 = be_merge(32'(vlim[0]), avs_writedata, avs_byteenable);
  wire [31:0] wd_v1 = be_merge(32'(vlim[1]), avs_writedata, avs_byteenable);
  wire [31:0] wd_t0 = be_merge(tgt_reg[0], avs_writedata, avs_byteenable);
  wire [31:0] wd_t1 = be_merge(tgt_reg[1], avs_writedata, avs_byteenable);

  // Status word
  wire busy = (state == TAC_PF) | (state == TAC_VL);
  wire [31:0] stat_word = (32'(pf) << `TAC_STAT_PF_LSB)
                        | (32'(rejected) << `TAC_STAT_REJ)
                        | (32'(busy) << `TAC_STAT_BUSY)
                        | (32'(prim) << `TAC_STAT_PRIM)
                        | (32'(coordinated_active) << `TAC_STAT_ACTIVE);
  wire [31:0] rd_mux = hit_mode ? mode_reg :
                       hit_v0 ? 32'(vlim[0]) :
                       hit_v1 ? 32'(vlim[1]) :
                       hit_t0 ? tgt_reg[0] :
                       hit_t1 ? tgt_reg[1] :
                       hit_st ? stat_word : 32'h00000000;

  // Handshake and read data; unmapped reads return zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack <= acc & ~ack;
      if (avs_read & ~ack) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Register writes; unmapped writes are dropped
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_reg <= `TAC_MODE_RST;
      vlim <= '{`TAC_VLIM_RST, `TAC_VLIM_RST};
      tgt_reg <= '{'0, '0};
    end else begin
      if (wr & hit_mode) mode_reg <= wd_mode & `TAC_MODE_MASK;
      if (wr & hit_v0) vlim[0] <= wd_v0[VW-1:0];
      if (wr & hit_v1) vlim[1] <= wd_v1[VW-1:0];
      if (wr_t0) tgt_reg[0] <= wd_t0;
      if (wr_t1) tgt_reg[1] <= wd_t1;
    end
  end

  // ****************************************************************
  // Target commit and trajectory check
  // ****************************************************************

  // With the latch set, axis 0 waits in its register for axis 1
  wire commit = wr_t1 | (wr_t0 & ~sync_en);
  wire signed [PW-1:0] c0 = sync_en ? tgt_reg[0] :
                            (wr_t0 ? signed'(wd_t0) : act_tgt[0]);
  wire signed [PW-1:0] c1 = wr_t1 ? signed'(wd_t1) : act_tgt[1];
  wire [PW:0] d0 = abs_diff(c0, ax_in[0].current_position);
  wire [PW:0] d1 = abs_diff(c1, ax_in[1].current_position);
  // Larger displacement leads; on a tie the higher limit leads
  wire new_prim = (d1 > d0) | ((d1 == d0) & (vlim[1] > vlim[0]));
  wire [PW:0] dp_new = new_prim ? d1 : d0;
  wire [PW:0] df_new = new_prim ? d0 : d1;

  // Follower target implied by the running factor
  wire [PW+FW:0] exp_full = dp_new * pf;
  wire [PW:0] exp_f = exp_full[PW+`TAC_PF_FRAC:`TAC_PF_FRAC];
  wire [PW:0] dev = (df_new >= exp_f) ? df_new - exp_f : exp_f - df_new;
  wire on_track = (new_prim == prim) & (dev <= (PW+1)'(TOLERANCE));

  // ****************************************************************
  // Shared restoring divider
  // ****************************************************************
  logic [DW-1:0] div_num, div_q;
  logic [PW:0] div_den;
  logic [PW+2:0] div_rem;
  logic [5:0] div_cnt;

  wire [PW+2:0] rem_sh = {div_rem[PW+1:0], div_num[DW-1]};
  wire q_bit = rem_sh >= {2'b00, div_den};
  wire [PW+2:0] rem_nx = q_bit ? rem_sh - {2'b00, div_den} : rem_sh;
  wire [DW-1:0] q_nx = {div_q[DW-2:0], q_bit};
  wire div_last = div_cnt == 6'h00;

  // Factor from a quotient with one guard bit, rounded half up
  wire [FW:0] pf_q = q_nx[FW:0];
  wire [FW:0] pf_sum = pf_q + (FW+1)'(1);
  wire [FW-1:0] pf_rnd = pf_sum[FW:1];
  // Division floors, so the limited speed can only come out lower
  wire [VW-1:0] lim_v = (|q_nx[DW-1:VW]) ? '1 : q_nx[VW-1:0];
  wire [VW-1:0] vp_own = vlim[prim];
  wire [VW-1:0] velocity_limit_new = (lim_v > vp_own) ? lim_v : vp_own;

  // Follower speed from the primary's present speed
  wire [VW+FW-1:0] fv_full = ax_in[prim].current_velocity * pf;
  wire [VW-1:0] fv_nx = fv_full[VW+`TAC_PF_FRAC-1:`TAC_PF_FRAC];

  wire any_stop = ax_in[0].stop | ax_in[1].stop;
  wire prim_done = ax_in[prim].current_position == act_tgt[prim];
  wire run = state == TAC_RUN;

  // ****************************************************************
  // Sequencer
  // ****************************************************************

  // Stops and a cleared enable always win, returning both axes to
  // their own ramps with the targets they already hold
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= TAC_IDLE;
      prim <= 1'b0;
      pf <= '0;
      velocity_limit_eff <= '0;
      act_tgt <= '{'0, '0};
      cand_tgt <= '{'0, '0};
      div_num <= '0;
      div_den <= '0;
      div_rem <= '0;
      div_q <= '0;
      div_cnt <= 6'h00;
    end else if (~coord_en | any_stop) begin
      state <= TAC_IDLE;
      if (commit & ~coord_en) begin
        act_tgt <= '{c0, c1};
      end
    end else begin
      unique case (state)
        TAC_IDLE: begin
          if (commit) begin
            // Both axes assumed standing here
            cand_tgt[0] <= c0;
            cand_tgt[1] <= c1;
            prim <= new_prim;
            div_num <= DW'({df_new, (FW)'(0)});
            div_den <= dp_new;
            div_rem <= '0;
            div_q <= '0;
            div_cnt <= 6'(DW - 1);
            state <= TAC_PF;
          end
        end
        TAC_PF: begin
          div_num <= {div_num[DW-2:0], 1'b0};
          div_rem <= rem_nx;
          div_q <= q_nx;
          div_cnt <= div_cnt - 6'h01;
          if (div_last) begin
            pf <= pf_rnd;
            if (pf_rnd == '0) begin
              // Follower stays put, primary keeps its own limit
              velocity_limit_eff <= vp_own;
              act_tgt <= cand_tgt;
              state <= TAC_RUN;
            end else begin
              div_num <= DW'({vlim[~prim], (`TAC_PF_FRAC)'(0)});
              div_den <= (PW+1)'(pf_rnd);
              div_rem <= '0;
              div_q <= '0;
              div_cnt <= 6'(DW - 1);
              state <= TAC_VL;
            end
          end
        end
        TAC_VL: begin
          div_num <= {div_num[DW-2:0], 1'b0};
          div_rem <= rem_nx;
          div_q <= q_nx;
          div_cnt <= div_cnt - 6'h01;
          if (div_last) begin
            velocity_limit_eff <= velocity_limit_new;
            act_tgt <= cand_tgt;
            state <= TAC_RUN;
          end
        end
        TAC_RUN: begin
          if (commit & on_track) begin
            act_tgt <= '{c0, c1};
          end else if (prim_done) begin
            state <= TAC_IDLE;
          end
        end
      endcase
    end
  end

  // Updates that arrive while busy or off track are dropped and
  // flagged; a new event wins over a write-one clear
  wire rej_set = coord_en & ~any_stop & commit & (busy | (run & ~on_track));
  wire rej_clr = wr & hit_st & avs_byteenable[0]
               & avs_writedata[`TAC_STAT_REJ];
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rejected <= 1'b0;
    end else begin
      rejected <= rej_set | (rejected & ~rej_clr);
    end
  end

  // ****************************************************************
  // Ramp commands
  // ****************************************************************
  tac_axis_cmd_t cmd [2];
  assign axis0_cmd = cmd[0];
  assign axis1_cmd = cmd[1];

  // The primary keeps its own ramp with the limit swapped; outside a
  // run each axis follows its own settings, so the follower's last
  // step and stop use its own ramp
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cmd <= '{'0, '0};
      coordinated_active <= 1'b0;
    end else begin
      coordinated_active <= run;
      for (int i = 0; i < 2; i++) begin
        cmd[i].target_position <= act_tgt[i];
        cmd[i].velocity_limit <= (run & (prim == 1'(i))) ? velocity_limit_eff
                                 : vlim[i];
        cmd[i].follow <= run & (prim != 1'(i));
        cmd[i].follow_velocity <= fv_nx;
      end
    end
  end

endmodule

/* src/tac_defines.svh */
/*
  Constants of the two-axis coordinated motion block: register word
  indexes, field positions, reset values and arithmetic widths.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef TAC_DEFINES_SVH
`define TAC_DEFINES_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define TAC_POS_W 32
`define TAC_VEL_W 23
`define TAC_PF_W 13
`define TAC_PF_FRAC 12
`define TAC_DIV_W 48

// ****************************************************************
// Register word indexes (byte address is four times the index)
// ****************************************************************
`define TAC_IDX_MODE 7'h07
`define TAC_IDX_VLIM0 7'h21
`define TAC_IDX_TGT0 7'h28
`define TAC_IDX_VLIM1 7'h56
`define TAC_IDX_TGT1 7'h5d
`define TAC_IDX_STAT 7'h7f

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define TAC_BIT_SYNC 8
`define TAC_BIT_COORD 9
`define TAC_MODE_MASK 32'h0000030f
`define TAC_MODE_RST 32'h00000000
`define TAC_VLIM_RST 23'h000000
`define TAC_STAT_ACTIVE 0
`define TAC_STAT_PRIM 1
`define TAC_STAT_BUSY 2
`define TAC_STAT_REJ 3
`define TAC_STAT_PF_LSB 16
`define TAC_TOL 3

`endif

/* src/tac_pkg.sv */
/*
  Types of the two-axis coordinated motion block.
  Assumes tac_defines.svh is on the include path.
*/
`include "tac_defines.svh"

package tac_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    TAC_IDLE = 4'b0001,
    TAC_PF = 4'b0010,
    TAC_VL = 4'b0100,
    TAC_RUN = 4'b1000
  } tac_state_t;

  // What one ramp generator reports
  typedef struct packed {
    logic signed [`TAC_POS_W-1:0] current_position;
    logic [`TAC_VEL_W-1:0] current_velocity;
    logic stop;
  } tac_axis_in_t;

  // What one ramp generator is told
  typedef struct packed {
    logic signed [`TAC_POS_W-1:0] target_position;
    logic [`TAC_VEL_W-1:0] velocity_limit;
    logic follow;
    logic [`TAC_VEL_W-1:0] follow_velocity;
  } tac_axis_cmd_t;

endpackage

/* tb/tac_coord_properties.sv */
/*
  Port-level assertions for the coordinated motion block.
  Assumes the bind below attaches it to every tac_coord instance.
*/
`timescale 1ns/1ps
// ****************************************************************
// Checker
// ****************************************************************
module tac_coord_properties
  import tac_pkg::*;
#(
  parameter int unsigned TOLERANCE = 3
) (
  input wire logic clock, // System clock
  input wire logic reset, // Asynchronous reset
  input wire logic [8:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic avs_waitrequest, // Slave not ready
  input wire tac_axis_in_t axis0_in, // Axis 0 state
  input wire tac_axis_in_t axis1_in, // Axis 1 state
  input wire tac_axis_cmd_t axis0_cmd, // Axis 0 command
  input wire tac_axis_cmd_t axis1_cmd, // Axis 1 command
  input wire logic coordinated_active // Move running
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // Decoded causes; a mode write clearing bit 9 must end the move
  wire req = avs_read | avs_write;
  wire stopped = axis0_in.stop | axis1_in.stop;
  wire mode_off = avs_write & ~avs_waitrequest & avs_byteenable[1] &
    (avs_address[8:2] == 7'h07) & ~avs_writedata[9];
  wire end0 = coordinated_active & axis1_cmd.follow &
    (axis0_in.current_position == axis0_cmd.target_position);
  wire end1 = coordinated_active & axis0_cmd.follow &
    (axis1_in.current_position == axis1_cmd.target_position);

  a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");
  a_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_one_follower:
    assert property (!(axis0_cmd.follow && axis1_cmd.follow))
    else $error("both axes follow");
  a_follow_bound0:
    assert property (axis0_cmd.follow |->
    axis0_cmd.follow_velocity <= $past(axis1_in.current_velocity))
    else $error("axis 0 follows faster than primary");
  a_follow_bound1:
    assert property (axis1_cmd.follow |->
    axis1_cmd.follow_velocity <= $past(axis0_in.current_velocity))
    else $error("axis 1 follows faster than primary");
  a_stop_abort:
    assert property (stopped |-> ##2 (!coordinated_active &&
    !axis0_cmd.follow && !axis1_cmd.follow))
    else $error("stop did not abort the move");
  a_end_primary0:
    assert property (end0 |-> ##[1:2] !coordinated_active)
    else $error("move kept running at axis 0 target");
  a_end_primary1:
    assert property (end1 |-> ##[1:2] !coordinated_active)
    else $error("move kept running at axis 1 target");
  a_mode_off:
    assert property (mode_off |-> ##[2:3] !coordinated_active)
    else $error("move survived mode disable");

  // Main scenarios reached
  cover property ($rose(coordinated_active));
  cover property (coordinated_active && stopped);
  cover property (end0 || end1);
endmodule

bind tac_coord tac_coord_properties #(.TOLERANCE(TOLERANCE)) u_props (
  .clock(clock), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .axis0_in(axis0_in),
  .axis1_in(axis1_in), .axis0_cmd(axis0_cmd), .axis1_cmd(axis1_cmd),
  .coordinated_active(coordinated_active));

/* tb/tac_coord_test.sv */
/*
  Self-checking bench: integer model of the coordination maths.
  Assumes the bench alone drives the bus and both ramp-state inputs.
*/
`timescale 1ns/1ps
// ****************************************************************
// Bench
// ****************************************************************
module tac_coord_test
  import tac_pkg::*;
;
  logic clock = 0;
  logic reset = 1;
  logic [8:0] avs_address = '0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, coordinated_active;
  tac_axis_in_t a0 = '0;
  tac_axis_in_t a1 = '0;
  tac_axis_cmd_t c0, c1, pc, fc;
  int failures = 0;
  int samples_checked = 0;

  tac_coord u_tac_coord (.clock(clock), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .axis0_in(a0), .axis1_in(a1),
    .axis0_cmd(c0), .axis1_cmd(c1), .coordinated_active(coordinated_active));

  // 125 MHz clock
  always #4 clock = ~clock;

  task wrap_up;
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task check(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One Avalon access; an edge first so strobes never toggle twice at once
  task bus(input logic w, input logic [8:0] a, input logic [31:0] d,
           input logic [3:0] be);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    if (n == 20) begin
      failures++;
      wrap_up;
    end
  endtask

  task wr(input logic [8:0] a, input logic [31:0] d);
    bus(1, a, d, 4'hf);
  endtask

  task rdc(input string what, input logic [8:0] a, input logic [31:0] e);
    bus(0, a, 0, 4'hf);
    check(what, e, rd);
  endtask

  // Start a move from position 0, check the model, optionally finish it
  task move(input int t0, input int t1, input int v0, input int v1,
            input bit fin);
    longint d0, d1, dp, df, pf, lim, vf, vp, vel;
    logic prim;
    int n;
    d0 = t0 < 0 ? -t0 : t0;
    d1 = t1 < 0 ? -t1 : t1;
    prim = (d1 > d0) || (d1 == d0 && v1 > v0);
    dp = prim ? d1 : d0;
    df = prim ? d0 : d1;
    vf = prim ? v0 : v1;
    vp = prim ? v1 : v0;
    pf = (df * 8192 + dp) / (2 * dp);
    lim = pf != 0 ? vf * 4096 / pf : 0;
    if (lim > 'h7fffff) lim = 'h7fffff;
    if (vp > lim) lim = vp;
    wr(9'h084, v0);
    wr(9'h158, v1);
    wr(9'h01c, 32'h300);
    wr(9'h0a0, t0);
    wr(9'h174, t1);
    for (n = 0; n < 300 && coordinated_active !== 1'b1; n++) tick(1);
    if (n == 300) begin
      failures++;
      wrap_up;
    end
    tick(2);
    pc = prim ? c1 : c0;
    fc = prim ? c0 : c1;
    bus(0, 9'h1fc, 0, 4'hf);
    check("factor", 32'(pf), 32'(rd[28:16]));
    check("primary", 32'(prim), 32'(rd[1]));
    check("tgt0", t0, c0.target_position);
    check("tgt1", t1, c1.target_position);
    if (pf != 0) check("vlim", 32'(lim), 32'(pc.velocity_limit));
    if (pf != 0) check("follow", 1, 32'(fc.follow));
    vel = $urandom_range(1, 32'h7fffff);
    if (prim) a1.current_velocity <= 23'(vel);
    else a0.current_velocity <= 23'(vel);
    tick(3);
    fc = prim ? c0 : c1;
    check("fvel", 32'(vel * pf / 4096), 32'(fc.follow_velocity));
    if (fin) begin
      if (prim) a1.current_position <= t1;
      else a0.current_position <= t0;
      tick(4);
      check("ended", 0, 32'(coordinated_active));
      check("own0", 0, 32'(c0.follow));
      check("own1", 0, 32'(c1.follow));
      // Axes settle at once here, so stop speed and standstill wait
      // match on both
      a0 <= '0; // Standstill before next start
      a1 <= '0;
    end
  endtask

  // Main sequence
  initial begin
    int i, t0, t1;
    void'($urandom(32'h04a2));
    tick(20);
    reset <= 0;
    tick(2);
    check("rst_act", 0, 32'(coordinated_active));
    check("rst_tgt", 0, c0.target_position);
    rdc("rst_mode", 9'h01c, 0);
    wr(9'h01c, 32'hffffffff);
    rdc("mode_mask", 9'h01c, 32'h30f);
    bus(1, 9'h084, 32'hffffffff, 4'h1);
    rdc("vlim_lane", 9'h084, 32'hff);
    wr(9'h084, 32'hffffffff);
    rdc("vlim_mask", 9'h084, 32'h7fffff);
    wr(9'h104, 32'h1234);
    rdc("unmapped", 9'h104, 0);
    wr(9'h01c, 32'h100);
    wr(9'h0a0, 111);
    tick(2);
    check("held0", 0, c0.target_position);
    wr(9'h174, 222);
    tick(2);
    check("pair0", 111, c0.target_position);
    check("pair1", 222, c1.target_position);
    wr(9'h01c, 32'h000);
    wr(9'h0a0, 333);
    tick(2);
    check("direct", 333, c0.target_position);
    move(500, -500, 100, 200, 1);
    move(-700, 0, 5000, 5000, 1);
    for (i = 0; i < 6; i++) begin
      t0 = $urandom_range(1, 200000);
      t1 = $urandom_range(0, 200000);
      if ($urandom_range(1, 0)) t0 = -t0;
      if ($urandom_range(1, 0)) t1 = -t1;
      move(t0, t1, $urandom_range(1, 32'h7fffff),
           $urandom_range(1, 32'h7fffff), 1);
    end
    // Trajectory tolerance at its edge, then abort by stop
    move(8000, 2000, 90000, 90000, 0);
    wr(9'h0a0, 24000);
    wr(9'h174, 6003);
    tick(2);
    check("otf0", 24000, c0.target_position);
    check("otf1", 6003, c1.target_position);
    // Factor 1024 in bits 28:16, running, axis 0 leads, nothing refused
    rdc("no_rej", 9'h1fc, 32'h04000001);
    check("rej0", 0, 32'(rd[3]));
    wr(9'h0a0, 28000);
    wr(9'h174, 7004);
    tick(2);
    bus(0, 9'h1fc, 0, 4'hf);
    check("rej1", 1, 32'(rd[3]));
    check("kept1", 6003, c1.target_position);
    wr(9'h1fc, 32'h8);
    bus(0, 9'h1fc, 0, 4'hf);
    check("rej_clr", 0, 32'(rd[3]));
    a1.stop <= 1;
    tick(3);
    check("abort", 0, 32'(coordinated_active));
    check("abort_f", 0, 32'(c1.follow));
    check("own_tgt", 24000, c0.target_position);
    a1.stop <= 0;
    move(3000, 1000, 40000, 40000, 0);
    wr(9'h01c, 32'h000);
    tick(3);
    check("mode_off", 0, 32'(coordinated_active));
    wrap_up;
  end
endmodule
